// >>> sppl_pkg.sv
// Shared constants, types and helpers of the system PLL control block
package sppl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W = 10;
  localparam int LVL_W = 8;
  localparam int INT_W = 3;
  localparam int EE_WAIT_DEFAULT = 1024;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
  localparam logic [7:0] ADDR_GPIO_SEL = 8'h10;
  localparam logic [7:0] ADDR_FREQ_M_LO = 8'h14;
  localparam logic [7:0] ADDR_FREQ_M_HI = 8'h18;
  localparam logic [7:0] ADDR_FREQ_N = 8'h1C;
  localparam logic [7:0] ADDR_LIMITS = 8'h20;

  localparam int CTRL_DBL_BIT = 0;
  localparam int CTRL_DIV_LSB = 8;
  localparam int CTRL_DIV_MSB = 17;
  localparam int ST_LOCKED = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_CLK_EN = 2;
  localparam int INT_LOL = 0;
  localparam int INT_LOAD = 1;
  localparam int INT_REJECT = 2;
  localparam int LIM_HI_LSB = 8;

  localparam logic [DIV_W-1:0] DIV_MIN = 10'h06C;
  localparam logic [DIV_W-1:0] DIV_MAX = 10'h22C;
  localparam logic [DIV_W-1:0] DIV_RST = 10'h1F4;
  localparam logic [LVL_W-1:0] LIM_BASE = 8'h40;
  localparam logic [LVL_W-1:0] LIM_SPAN = 8'h10;
  localparam logic [LVL_W-1:0] LIM_DBL_OFS = 8'h08;
  localparam logic [47:0] FREQ_M_RST = 48'h0000_017D_7840;
  localparam logic [15:0] FREQ_N_RST = 16'h0001;

  typedef struct packed {
    logic doubler;
    logic [DIV_W-1:0] fb_div;
  } sppl_cfg_s;

  typedef struct packed {
    logic [47:0] num;
    logic [15:0] den;
  } sppl_freq_s;

  typedef enum logic [1:0] {
    LD_START = 2'b00,
    LD_EEPROM = 2'b01,
    LD_DONE = 2'b10,
    LD_IDLE = 2'b11
  } sppl_ld_e;

  localparam sppl_cfg_s CFG_RST = '{doubler: 1'b0, fb_div: DIV_RST};

  function automatic logic sppl_div_ok(input logic [DIV_W-1:0] d);
    return (d >= DIV_MIN) && (d <= DIV_MAX);
  endfunction : sppl_div_ok

  // Window centre moves with the loop's operating point
  function automatic logic [LVL_W-1:0] sppl_centre(input sppl_cfg_s c);
    return LIM_BASE + c.fb_div[DIV_W-1:2] + (c.doubler ? LIM_DBL_OFS : 8'h00);
  endfunction : sppl_centre
endpackage : sppl_pkg

// >>> sppl_loader.sv
// Reset-time configuration loader, one-time memory first, then EEPROM
`timescale 1ns/1ps
module sppl_loader
  import sppl_pkg::*;
#(
  parameter int EE_WAIT_CYCLES = EE_WAIT_DEFAULT
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic otp_en, // One-time memory source enabled
  input wire logic otp_valid, // One-time memory contents valid
  input wire sppl_cfg_s otp_cfg, // One-time memory settings
  input wire logic ee_en, // EEPROM source enabled
  input wire logic ee_ack, // EEPROM fetch finished
  input wire logic ee_valid, // EEPROM contents valid
  input wire sppl_cfg_s ee_cfg, // EEPROM settings
  output logic ee_req, // EEPROM fetch request
  output logic busy, // Reset sequence running
  output logic load, // Load pulse toward the settings register
  output logic done, // Sequence finished pulse
  output sppl_cfg_s cfg // Settings to load
);
  localparam int CW = $clog2(EE_WAIT_CYCLES + 1);
  if (EE_WAIT_CYCLES < 1) begin : g_bad_wait
    $error("EE_WAIT_CYCLES must be at least one");
  end
  sppl_ld_e state;
  logic [CW-1:0] wait_cnt;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= LD_START;
      ee_req <= 1'b0;
      busy <= 1'b1;
      load <= 1'b0;
      done <= 1'b0;
      cfg <= CFG_RST;
      wait_cnt <= '0;
    end else begin
      load <= 1'b0;
      done <= 1'b0;
      case (state)
        LD_START: begin
          if (otp_en && otp_valid && sppl_div_ok(otp_cfg.fb_div)) begin
            cfg <= otp_cfg;
            load <= 1'b1;
            state <= LD_DONE;
          end else if (ee_en) begin
            ee_req <= 1'b1;
            state <= LD_EEPROM;
          end else begin
            state <= LD_DONE;
          end
        end
        LD_EEPROM: begin
          wait_cnt <= wait_cnt + 1'b1;
          if (ee_ack || wait_cnt == CW'(EE_WAIT_CYCLES)) begin
            ee_req <= 1'b0;
            state <= LD_DONE;
            if (ee_ack && ee_valid && sppl_div_ok(ee_cfg.fb_div)) begin
              cfg <= ee_cfg;
              load <= 1'b1;
            end
          end
        end
        LD_DONE: begin
          busy <= 1'b0;
          done <= 1'b1;
          state <= LD_IDLE;
        end
        default: state <= LD_IDLE;
      endcase
    end
  end

  property p_otp_first;
    @(posedge clk) disable iff (!reset_n)
      // The release edge still samples reset low, so it starts no check
      (reset_n && state == LD_START && otp_en && otp_valid && sppl_div_ok(otp_cfg.fb_div))
      |=> (load && cfg == $past(otp_cfg) && !ee_req);
  endproperty
  a_otp_first: assert property (p_otp_first) else $error("OTP settings not loaded");
endmodule : sppl_loader

// >>> sppl_lockdet.sv
// Lock detector: synchronises the loop control level, compares with own limits
`timescale 1ns/1ps
module sppl_lockdet
  import sppl_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [LVL_W-1:0] level_in, // Loop control level from the analog side
  input wire sppl_cfg_s cfg, // Active settings
  output logic locked, // Level inside the window
  output logic [LVL_W-1:0] lim_lo, // Lower limit
  output logic [LVL_W-1:0] lim_hi // Upper limit
);
  logic [LVL_W-1:0] s1, s2, s3, lvl;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      lvl <= '0;
    end else begin
      s1 <= level_in;
      s2 <= s1;
      s3 <= s2;
      // A code caught mid-change is held off until two stages agree
      if (s2 == s3) begin
        lvl <= s3;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Empty window in reset, so no false lock follows its release
      lim_lo <= '1;
      lim_hi <= '0;
      locked <= 1'b0;
    end else begin
      lim_lo <= sppl_centre(cfg) - LIM_SPAN;
      lim_hi <= sppl_centre(cfg) + LIM_SPAN;
      locked <= (lvl >= lim_lo) && (lvl <= lim_hi);
    end
  end

  property p_window;
    @(posedge clk) disable iff (!reset_n)
      (lvl >= lim_lo && lvl <= lim_hi) |=> locked;
  endproperty
  a_window: assert property (p_window) else $error("Lock missed inside window");
endmodule : sppl_lockdet

// >>> sppl_top.sv
// System PLL settings, reset load, lock status and loss-of-lock alarm
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Frequencies held as 48-bit over 16-bit fraction
// - Setting selects direct or doubled crystal reference
// - Feedback divider programmable 108 through 556
// - PLL output is the only internal clock source
// - Reset loads settings from valid enabled source
// - Serial-port reconfiguration accepted after reset sequence
// - Lock limits derived from active settings
// - Loss-of-lock alarm readable, GPIO selectable
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module sppl_top
  import sppl_pkg::*;
#(
  parameter int EE_WAIT_CYCLES = EE_WAIT_DEFAULT
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] reg_addr, // Register byte address
  input wire logic [DATA_W-1:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
  input wire logic otp_en, // One-time memory source enabled
  input wire logic otp_valid, // One-time memory contents valid
  input wire sppl_cfg_s otp_cfg, // One-time memory settings
  input wire logic ee_en, // EEPROM source enabled
  input wire logic ee_ack, // EEPROM fetch finished
  input wire logic ee_valid, // EEPROM contents valid
  input wire sppl_cfg_s ee_cfg, // EEPROM settings
  output logic ee_req, // EEPROM fetch request
  input wire logic [LVL_W-1:0] loop_level, // Loop control level
  output sppl_cfg_s pll_cfg, // Settings to the analog loop
  output logic pll_clk_enable, // Release of derived clocks
  output logic pll_locked, // Lock status
  output logic gpio_alarm, // Alarm to the GPIO status pin
  output logic irq // Interrupt, level
);
  sppl_cfg_s cfg;
  sppl_cfg_s ld_cfg;
  sppl_cfg_s wr_cfg;
  sppl_freq_s freq;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] next_int_stat;
  logic [INT_W-1:0] events;
  logic gpio_sel;
  logic ld_busy, ld_load, ld_done;
  logic det_locked, locked_prev;
  logic [LVL_W-1:0] lim_lo, lim_hi;
  logic ctrl_wr, ctrl_ok, den_wr, den_bad;

  ////////////////////////////////////////////////////////////////////////////////
  sppl_loader #(
    .EE_WAIT_CYCLES(EE_WAIT_CYCLES)
  ) u_loader (
    .clk(clk),
    .reset_n(reset_n),
    .otp_en(otp_en),
    .otp_valid(otp_valid),
    .otp_cfg(otp_cfg),
    .ee_en(ee_en),
    .ee_ack(ee_ack),
    .ee_valid(ee_valid),
    .ee_cfg(ee_cfg),
    .ee_req(ee_req),
    .busy(ld_busy),
    .load(ld_load),
    .done(ld_done),
    .cfg(ld_cfg)
  );

  sppl_lockdet u_lockdet (
    .clk(clk),
    .reset_n(reset_n),
    .level_in(loop_level),
    .cfg(cfg),
    .locked(det_locked),
    .lim_lo(lim_lo),
    .lim_hi(lim_hi)
  );

  assign pll_locked = det_locked;

  ////////////////////////////////////////////////////////////////////////////////
  assign wr_cfg = '{doubler: reg_wdata[CTRL_DBL_BIT],
                    fb_div: reg_wdata[CTRL_DIV_MSB:CTRL_DIV_LSB]};
  assign ctrl_wr = reg_wr && (reg_addr == ADDR_CTRL);
  // Writes racing the reset load would be overwritten, so they are refused
  assign ctrl_ok = ctrl_wr && !ld_busy && sppl_div_ok(wr_cfg.fb_div);
  assign den_wr = reg_wr && (reg_addr == ADDR_FREQ_N);
  assign den_bad = den_wr && (reg_wdata[15:0] == 16'h0000);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg <= CFG_RST;
    end else if (ld_load) begin
      cfg <= ld_cfg;
    end else if (ctrl_ok) begin
      cfg <= wr_cfg;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pll_cfg <= CFG_RST;
      pll_clk_enable <= 1'b0;
    end else begin
      pll_cfg <= cfg;
      // Derived clocks stay gated until the single source is settled
      pll_clk_enable <= !ld_busy && det_locked;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      freq <= '{num: FREQ_M_RST, den: FREQ_N_RST};
    end else if (reg_wr) begin
      if (reg_addr == ADDR_FREQ_M_LO) begin
        freq.num[31:0] <= reg_wdata;
      end
      if (reg_addr == ADDR_FREQ_M_HI) begin
        freq.num[47:32] <= reg_wdata[15:0];
      end
      if (den_wr && !den_bad) begin
        freq.den <= reg_wdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      locked_prev <= 1'b0;
    end else begin
      locked_prev <= det_locked;
    end
  end

  always_comb begin
    events = '0;
    events[INT_LOL] = locked_prev && !det_locked;
    events[INT_LOAD] = ld_done;
    events[INT_REJECT] = (ctrl_wr && !ctrl_ok) || den_bad;
    next_int_stat = int_stat;
    if (reg_wr && reg_addr == ADDR_INT_STAT) begin
      next_int_stat = int_stat & ~reg_wdata[INT_W-1:0];
    end
    // A new event beats a clear arriving in the same cycle
    next_int_stat = next_int_stat | events;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_stat <= '0;
      int_mask <= '0;
      gpio_sel <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      if (reg_wr && reg_addr == ADDR_INT_MASK) begin
        int_mask <= reg_wdata[INT_W-1:0];
      end
      if (reg_wr && reg_addr == ADDR_GPIO_SEL) begin
        gpio_sel <= reg_wdata[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
      gpio_alarm <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
      gpio_alarm <= gpio_sel && int_stat[INT_LOL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_CTRL: begin
            reg_rdata[CTRL_DBL_BIT] <= cfg.doubler;
            reg_rdata[CTRL_DIV_MSB:CTRL_DIV_LSB] <= cfg.fb_div;
          end
          ADDR_STATUS: begin
            reg_rdata[ST_LOCKED] <= det_locked;
            reg_rdata[ST_BUSY] <= ld_busy;
            reg_rdata[ST_CLK_EN] <= pll_clk_enable;
          end
          ADDR_INT_STAT: reg_rdata[INT_W-1:0] <= int_stat;
          ADDR_INT_MASK: reg_rdata[INT_W-1:0] <= int_mask;
          ADDR_GPIO_SEL: reg_rdata[0] <= gpio_sel;
          ADDR_FREQ_M_LO: reg_rdata <= freq.num[31:0];
          ADDR_FREQ_M_HI: reg_rdata[15:0] <= freq.num[47:32];
          ADDR_FREQ_N: reg_rdata[15:0] <= freq.den;
          ADDR_LIMITS: begin
            reg_rdata[LVL_W-1:0] <= lim_lo;
            reg_rdata[LIM_HI_LSB+LVL_W-1:LIM_HI_LSB] <= lim_hi;
          end
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_unlock;
    det_locked ##1 !det_locked;
  endsequence

  sequence s_busy_write;
    ld_busy && ctrl_wr;
  endsequence

  property p_div_range;
    @(posedge clk) disable iff (!reset_n)
      sppl_div_ok(cfg.fb_div);
  endproperty
  a_div_range: assert property (p_div_range) else $error("Divider out of range");

  property p_ctrl_take;
    @(posedge clk) disable iff (!reset_n)
      (ctrl_wr && !ld_busy && sppl_div_ok(wr_cfg.fb_div)) |=> ##1 (pll_cfg == $past(wr_cfg, 2));
  endproperty
  a_ctrl_take: assert property (p_ctrl_take) else $error("Setting write not applied");

  property p_busy_refuse;
    @(posedge clk) disable iff (!reset_n)
      (s_busy_write ##0 !ld_load) |=> ($stable(cfg) && int_stat[INT_REJECT]);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("Write taken during load");

  property p_lol_alarm;
    @(posedge clk) disable iff (!reset_n)
      s_unlock |=> int_stat[INT_LOL];
  endproperty
  a_lol_alarm: assert property (p_lol_alarm) else $error("Loss of lock not flagged");

  property p_status_read;
    @(posedge clk) disable iff (!reset_n)
      (reg_rd && reg_addr == ADDR_STATUS) |=> (reg_rdata[ST_LOCKED] == $past(det_locked));
  endproperty
  a_status_read: assert property (p_status_read) else $error("Lock status misread");

  property p_gpio;
    @(posedge clk) disable iff (!reset_n)
      (gpio_sel && int_stat[INT_LOL]) [*2] |-> gpio_alarm;
  endproperty
  a_gpio: assert property (p_gpio) else $error("Alarm missing on GPIO");

  property p_clk_gate;
    @(posedge clk) disable iff (!reset_n)
      pll_clk_enable |-> ($past(det_locked) && !$past(ld_busy));
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("Clocks released early");

  property p_den_nonzero;
    @(posedge clk) disable iff (!reset_n)
      den_bad |=> (freq.den != 16'h0000 && int_stat[INT_REJECT]);
  endproperty
  a_den_nonzero: assert property (p_den_nonzero) else $error("Zero denominator taken");

  property p_load_then_free;
    @(posedge clk) disable iff (!reset_n)
      ld_load |=> (cfg == $past(ld_cfg)) ##[1:2] !ld_busy;
  endproperty
  a_load_then_free: assert property (p_load_then_free) else $error("Load sequence broken");

  property p_range_refuse;
    @(posedge clk) disable iff (!reset_n)
      (ctrl_wr && !sppl_div_ok(wr_cfg.fb_div) && !ld_load)
      |=> ($stable(cfg) && int_stat[INT_REJECT]);
  endproperty
  a_range_refuse: assert property (p_range_refuse) else $error("Bad divider taken");

  property p_lol_clear;
    @(posedge clk) disable iff (!reset_n)
      (reg_wr && reg_addr == ADDR_INT_STAT && reg_wdata[INT_LOL] && !events[INT_LOL])
      |=> !int_stat[INT_LOL];
  endproperty
  a_lol_clear: assert property (p_lol_clear) else $error("Alarm not cleared");

  property p_irq_raise;
    @(posedge clk) disable iff (!reset_n)
      (|(int_stat & int_mask)) |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("Interrupt missing");

  property p_rdata_idle;
    @(posedge clk) disable iff (!reset_n)
      !reg_rd |=> (reg_rdata == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data left standing");

  property p_clk_release;
    @(posedge clk) disable iff (!reset_n)
      (det_locked && !ld_busy) |=> pll_clk_enable;
  endproperty
  a_clk_release: assert property (p_clk_release) else $error("Clocks not released");
endmodule : sppl_top

// >>> sppl_ee_model.sv
// Configuration EEPROM as seen through the loader's fetch handshake
`timescale 1ns/1ps
module sppl_ee_model
  import sppl_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic ee_req, // Fetch request from the loader
  input wire logic [7:0] delay, // Cycles from request to answer
  input wire logic good, // Report stored contents as valid
  input wire sppl_cfg_s data, // Stored settings
  output logic ee_ack, // Fetch finished pulse
  output logic ee_valid, // Contents valid, beside ee_ack
  output sppl_cfg_s ee_cfg // Settings, beside ee_ack
);
  logic [7:0] wait_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // One answer per request; the count stops at delay+1 so no second pulse follows, except for delay 255, where it wraps
  always_ff @(posedge clk) begin
    if (!reset_n || !ee_req) begin
      wait_cnt <= 8'h00;
      ee_ack <= 1'b0;
    end else begin
      ee_ack <= (wait_cnt == delay);
      if (wait_cnt <= delay) begin
        wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outside the answer cycle the lines show the inverse, never stale contents
  assign ee_valid = ee_ack ? good : !good;
  assign ee_cfg = ee_ack ? data : sppl_cfg_s'(~data);
endmodule : sppl_ee_model

// >>> sppl_top_bench.sv
// Self-checking bench of the system PLL control block
`timescale 1ns/1ps
module sppl_top_bench
  import sppl_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic otp_en = 1'b0;
  logic otp_valid = 1'b0;
  sppl_cfg_s otp_cfg = CFG_RST;
  logic ee_en = 1'b1;
  logic ee_ack, ee_valid, ee_req;
  sppl_cfg_s ee_cfg, pll_cfg, c, exp_cfg;
  logic [LVL_W-1:0] loop_level = '0;
  logic pll_clk_enable, pll_locked, gpio_alarm, irq;
  logic [7:0] ee_delay = 8'h03;
  logic ee_good = 1'b1;
  // Stored settings give 13.6 GHz from an assumed 50 MHz crystal
  sppl_cfg_s ee_data = '{doubler: 1'b1, fb_div: 10'h088};
  logic [9:0] divs [4] = '{10'h06B, 10'h06C, 10'h22C, 10'h22D};
  logic ee_seen, ok;
  logic [DATA_W-1:0] d;
  logic [47:0] m;
  logic [15:0] n;
  int err_total = 0;
  int cmp_count = 0;

  always #10 clk = ~clk;
  always @(posedge clk) ee_seen <= !reset_n ? 1'b0 : (ee_seen || ee_req === 1'b1);

  sppl_top #(.EE_WAIT_CYCLES(8)) DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .otp_en(otp_en), .otp_valid(otp_valid), .otp_cfg(otp_cfg), .ee_en(ee_en),
    .ee_ack(ee_ack), .ee_valid(ee_valid), .ee_cfg(ee_cfg), .ee_req(ee_req),
    .loop_level(loop_level), .pll_cfg(pll_cfg), .pll_clk_enable(pll_clk_enable),
    .pll_locked(pll_locked), .gpio_alarm(gpio_alarm), .irq(irq));

  sppl_ee_model ee_model (.clk(clk), .reset_n(reset_n), .ee_req(ee_req), .delay(ee_delay),
    .good(ee_good), .data(ee_data), .ee_ack(ee_ack), .ee_valid(ee_valid), .ee_cfg(ee_cfg));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // Host accesses, usable at any time after the reset sequence
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic do_reset(input logic use_otp, input sppl_cfg_s oc, input logic good);
    reset_n <= 1'b0;
    otp_en <= use_otp;
    otp_valid <= use_otp;
    otp_cfg <= oc;
    ee_good <= good;
    loop_level <= '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  task automatic wait_ready();
    int i;
    d = '1;
    for (i = 0; i < 40 && d[ST_BUSY] !== 1'b0; i++) rd(ADDR_STATUS, d);
    check(d[ST_BUSY], 1'b0);
  endtask : wait_ready

  task automatic wait_lock(input logic v);
    int i;
    for (i = 0; i < 30 && pll_locked !== v; i++) tick(1);
    check(pll_locked, v);
  endtask : wait_lock

  function automatic logic [7:0] centre(input sppl_cfg_s s);
    return 8'h40 + s.fb_div[9:2] + (s.doubler ? 8'h08 : 8'h00);
  endfunction : centre

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0000_A547));
    do_reset(1'b0, CFG_RST, 1'b1);
    wait_ready();
    check(ee_seen, 1'b1);
    check(pll_cfg, ee_data);
    rd(ADDR_INT_STAT, d);
    check(d[INT_LOAD], 1'b1);
    wr(ADDR_INT_STAT, 32'h0000_0007);
    exp_cfg = ee_data;
    rd(ADDR_FREQ_M_LO, d);
    check(d, FREQ_M_RST[31:0]);
    rd(ADDR_FREQ_N, d);
    check(d, {16'h0000, FREQ_N_RST});
    m = {16'($urandom()), 32'($urandom())};
    n = 16'($urandom_range(32'h0000_FFFF, 32'h0000_0001));
    wr(ADDR_FREQ_M_LO, m[31:0]);
    wr(ADDR_FREQ_M_HI, {16'h0000, m[47:32]});
    wr(ADDR_FREQ_N, {16'h0000, n});
    wr(ADDR_FREQ_N, 32'h0000_0000);
    rd(ADDR_FREQ_M_LO, d);
    check(d, m[31:0]);
    rd(ADDR_FREQ_M_HI, d);
    check(d, {16'h0000, m[47:32]});
    rd(ADDR_FREQ_N, d);
    check(d, {16'h0000, n});
    rd(ADDR_INT_STAT, d);
    check(d[INT_REJECT], 1'b1);
    wr(ADDR_INT_STAT, 32'h0000_0004);
    // Divider edges first, then random settings inside the range
    for (int k = 0; k < 12; k++) begin
      c.doubler = k[0];
      c.fb_div = k < 4 ? divs[k] : DIV_MIN + 10'($urandom_range(32'h0000_01C0, 0));
      wr(ADDR_CTRL, {14'h0000, c.fb_div, 7'h00, c.doubler});
      ok = c.fb_div >= 10'h06C && c.fb_div <= 10'h22C;
      if (ok) exp_cfg = c;
      tick(1);
      check(pll_cfg, exp_cfg);
      rd(ADDR_LIMITS, d);
      check(d, {16'h0000, centre(exp_cfg) + 8'h10, centre(exp_cfg) - 8'h10});
      rd(ADDR_INT_STAT, d);
      check(d[INT_REJECT], !ok);
      wr(ADDR_INT_STAT, 32'h0000_0004);
    end
    rd(8'h24, d);
    check(d, 32'h0000_0000);
    wr(ADDR_INT_MASK, 32'h0000_0001);
    wr(ADDR_GPIO_SEL, 32'h0000_0001);
    loop_level <= centre(exp_cfg) + 8'h10;
    wait_lock(1'b1);
    tick(2);
    check(pll_clk_enable, 1'b1);
    rd(ADDR_STATUS, d);
    check(d[2:0], 3'b101);
    check(irq, 1'b0);
    loop_level <= centre(exp_cfg) + 8'h11;
    wait_lock(1'b0);
    tick(3);
    check(irq, 1'b1);
    check(gpio_alarm, 1'b1);
    rd(ADDR_INT_STAT, d);
    check(d[INT_LOL], 1'b1);
    wr(ADDR_INT_MASK, 32'h0000_0000);
    tick(2);
    check(irq, 1'b0);
    wr(ADDR_INT_STAT, 32'h0000_0001);
    tick(2);
    check(gpio_alarm, 1'b0);
    // A second loss must raise the alarm again
    loop_level <= centre(exp_cfg) - 8'h10;
    wait_lock(1'b1);
    loop_level <= centre(exp_cfg) - 8'h11;
    wait_lock(1'b0);
    tick(3);
    check(gpio_alarm, 1'b1);
    c = '{doubler: 1'b0, fb_div: 10'h110};
    do_reset(1'b1, c, 1'b1);
    wait_ready();
    check(pll_cfg, c);
    check(ee_seen, 1'b0);
    // Invalid EEPROM keeps defaults; a CTRL write during loading is refused
    ee_delay <= 8'h06;
    do_reset(1'b0, c, 1'b0);
    wr(ADDR_CTRL, 32'h0001_0001);
    wait_ready();
    check(pll_cfg, CFG_RST);
    rd(ADDR_INT_STAT, d);
    check(d[INT_REJECT], 1'b1);
    // A silent EEPROM times out and defaults stay; with no source the fetch is skipped
    ee_delay <= 8'h40;
    do_reset(1'b0, c, 1'b1);
    wait_ready();
    check(ee_seen, 1'b1);
    check(pll_cfg, CFG_RST);
    ee_en <= 1'b0;
    do_reset(1'b0, c, 1'b1);
    wait_ready();
    check(ee_seen, 1'b0);
    print_verdict();
  end

  initial begin
    #400_000;
    err_total++;
    print_verdict();
  end
endmodule : sppl_top_bench
